// ---- inc/debug_csr_pkg.sv ----
// constants and types for the debug control/status upper byte
// Function
// - upper byte readable in every mode, only over the debug serial link
// - writes accepted only while unsecured, each bit further restricted
// - bits 7, 3, 2 written only by the register write command
// - bit 5 written by register write only outside stop mode
// - bits 6, 1, 0 ignore writes; hardware events only
// - enable set permits active debug and non-intrusive commands
// - special single-chip reset sets debug enable
// - active status set on debug entry while enabled, cleared on exit sequence
// - special single-chip reset sets active status
// - with enable, bit 5 picks serial clock only or all clocks in stop
// - with enable clear, debug has no stop influence, no communication in stop
// - with handshake and debug enable on, first acknowledge after stop entry is long
// - handshake on: steal uses next cycle, else wait free, 512 timeout
// - handshake off: always steal the next bus cycle
// - clock switch picks dedicated debug clock or device fast clock
// - reset clears clock switch; once set only reset clears it
// - unsecure indicator follows unsecured state, zero when secure
// - erase pending set only by erase command, not by register writes
// - erase pending cleared at erase finish or soft reset
// - two-byte register reached only by serial read/write commands
package debug_csr_pkg;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_ACTIVE = 6;
	localparam int BIT_CIS = 5;
	localparam int BIT_RSVD = 4;
	localparam int BIT_STEAL = 3;
	localparam int BIT_SERIAL_CLOCK_SOURCE_SWITCH = 2;
	localparam int BIT_UNSECURE_INDICATOR = 1;
	localparam int BIT_ERASE = 0;
	localparam logic [7:0] RESET_NORMAL = 8'h00;
	localparam logic [7:0] RESET_SPECIAL = 8'hC0;
	localparam int FREE_WAIT_TIMEOUT = 512;
	localparam int SERIAL_CLOCK_SOURCE_SWITCH_SETTLE_CYCLES = 150;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_WAIT = 2'b01,
		ACC_GO = 2'b11
	} acc_state_t;
endpackage

// ---- verilog/debug_bus_access.sv ----
// bus access arbiter for debug accesses: steal or wait for a free cycle
`timescale 1ns/1ps
`default_nettype none
module debug_bus_access #(
	parameter int TIMEOUT = debug_csr_pkg::FREE_WAIT_TIMEOUT
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_req,
	input wire logic i_ack_enabled,
	input wire logic i_steal,
	input wire logic i_bus_free,
	output logic o_grant,
	output logic o_timeout
);
	localparam int CW = $clog2(TIMEOUT + 1);
	localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);
	initial begin
		if (TIMEOUT < 1) begin
			$error("timeout must be at least one cycle");
		end
	end
	debug_csr_pkg::acc_state_t state;
	debug_csr_pkg::acc_state_t next_state;
	logic [CW-1:0] count;
	// steal next cycle unless handshake on and steal clear
	wire steal_now = !i_ack_enabled || i_steal;
	wire wait_done = (count == LAST);
	always_comb begin
		next_state = state;
		unique case (state)
			debug_csr_pkg::ACC_IDLE: begin
				if (i_req) begin
					next_state = steal_now ? debug_csr_pkg::ACC_GO :
						debug_csr_pkg::ACC_WAIT;
				end
			end
			debug_csr_pkg::ACC_WAIT: begin
				if (i_bus_free || wait_done) begin
					next_state = debug_csr_pkg::ACC_GO;
				end
			end
			debug_csr_pkg::ACC_GO: begin
				next_state = debug_csr_pkg::ACC_IDLE;
			end
			default: next_state = debug_csr_pkg::ACC_IDLE;
		endcase
	end
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			state <= debug_csr_pkg::ACC_IDLE;
			count <= '0;
			o_timeout <= 1'b0;
		end else begin
			state <= next_state;
			count <= (state == debug_csr_pkg::ACC_WAIT) ? count + 1'b1 : '0;
			// timeout after the free-cycle wait expires
			o_timeout <= (state == debug_csr_pkg::ACC_WAIT) && wait_done &&
				!i_bus_free;
		end
	end
	assign o_grant = (state == debug_csr_pkg::ACC_GO);
endmodule
`default_nettype wire

// ---- verilog/debug_ctrl_status_upper.sv ----
// upper byte of the debug control/status register with its side effects
`timescale 1ns/1ps
`default_nettype none
module debug_ctrl_status_upper #(
	parameter int TIMEOUT = debug_csr_pkg::FREE_WAIT_TIMEOUT
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_soft_reset,
	input wire logic i_special_mode,
	input wire logic i_secure,
	input wire logic i_stop_mode,
	input wire logic i_reg_write_cmd,
	input wire logic i_reg_read_cmd,
	input wire logic [7:0] i_write_data,
	input wire logic i_erase_cmd,
	input wire logic i_erase_done,
	input wire logic i_debug_entry,
	input wire logic i_debug_exit,
	input wire logic i_ack_enabled,
	input wire logic i_ack_issue,
	input wire logic i_access_req,
	input wire logic i_bus_free,
	input wire logic i_dedicated_debug_clock_input,
	input wire logic i_fast_clock,
	output logic [7:0] o_read_data,
	output logic o_read_valid,
	output logic o_debug_enable,
	output logic o_active_debug_status,
	output logic o_continue_in_stop_select,
	output logic o_serial_clock_source_switch,
	output logic o_debug_serial_timing_clock,
	output logic o_serial_clock_run_in_stop,
	output logic o_all_clocks_run_in_stop,
	output logic o_debug_comm_allowed,
	output logic o_active_debug_allowed,
	output logic o_full_command_set,
	output logic o_long_ack,
	output logic o_access_grant,
	output logic o_access_timeout
);
	logic debug_enable;
	logic active_debug_status;
	logic continue_in_stop_select;
	logic steal;
	logic serial_clock_source_switch;
	logic erase_pending;
	logic stop_seen;
	logic stop_q;
	logic reset_q;

	wire write_ok = i_reg_write_cmd && !i_secure;
	wire cis_write = write_ok && !i_stop_mode;
	// unsecure indicator is the live inverse of security
	wire unsecure_indicator = !i_secure;
	// reset release strobe used to sample the mode strap
	wire reset_release = reset_q && !i_reset;
	wire stop_entry = i_stop_mode && !stop_q;

	wire [7:0] status_byte = {
		debug_enable,
		active_debug_status,
		continue_in_stop_select,
		1'b0,
		steal,
		serial_clock_source_switch,
		unsecure_indicator,
		erase_pending
	};

	always_ff @(posedge i_ref_clk) begin
		reset_q <= i_reset;
		stop_q <= i_reset ? 1'b0 : i_stop_mode;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			debug_enable <= debug_csr_pkg::RESET_NORMAL[debug_csr_pkg::BIT_ENABLE];
			steal <= debug_csr_pkg::RESET_NORMAL[debug_csr_pkg::BIT_STEAL];
		end else if (reset_release) begin
			debug_enable <= i_special_mode;
		end else if (write_ok) begin
			// enable and steal via register write command only
			debug_enable <= i_write_data[debug_csr_pkg::BIT_ENABLE];
			steal <= i_write_data[debug_csr_pkg::BIT_STEAL];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			continue_in_stop_select <=
				debug_csr_pkg::RESET_NORMAL[debug_csr_pkg::BIT_CIS];
		end else if (cis_write) begin
			continue_in_stop_select <= i_write_data[debug_csr_pkg::BIT_CIS];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			serial_clock_source_switch <=
				debug_csr_pkg::RESET_NORMAL[debug_csr_pkg::BIT_SERIAL_CLOCK_SOURCE_SWITCH];
		end else if (write_ok && i_write_data[debug_csr_pkg::BIT_SERIAL_CLOCK_SOURCE_SWITCH]) begin
			// sticky once set, only reset clears
			serial_clock_source_switch <= 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			active_debug_status <=
				debug_csr_pkg::RESET_NORMAL[debug_csr_pkg::BIT_ACTIVE];
		end else if (reset_release) begin
			// special single-chip mode starts in active debug
			active_debug_status <= i_special_mode;
		end else if (i_debug_entry && debug_enable) begin
			// set on entry; entry wins over exit
			active_debug_status <= 1'b1;
		end else if (i_debug_exit) begin
			active_debug_status <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			erase_pending <= debug_csr_pkg::RESET_NORMAL[debug_csr_pkg::BIT_ERASE];
		end else if (i_erase_cmd) begin
			// only the erase command sets it; set wins
			erase_pending <= 1'b1;
		end else if (i_erase_done || i_soft_reset) begin
			// cleared at erase completion or soft reset
			erase_pending <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			stop_seen <= 1'b0;
		end else if (stop_entry && debug_enable) begin
			// arm long acknowledge on stop entry
			stop_seen <= 1'b1;
		end else if (i_ack_issue) begin
			stop_seen <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			o_read_data <= 8'h00;
			o_read_valid <= 1'b0;
		end else begin
			// read only through the serial read command
			o_read_valid <= i_reg_read_cmd;
			if (i_reg_read_cmd) begin
				o_read_data <= status_byte;
			end
		end
	end

	assign o_debug_enable = debug_enable;
	assign o_active_debug_status = active_debug_status;
	assign o_continue_in_stop_select = continue_in_stop_select;
	assign o_serial_clock_source_switch = serial_clock_source_switch;
	assign o_debug_serial_timing_clock = serial_clock_source_switch ?
		i_fast_clock : i_dedicated_debug_clock_input;
	// stop clock behaviour only with debug enabled
	assign o_serial_clock_run_in_stop = debug_enable;
	assign o_all_clocks_run_in_stop = debug_enable && continue_in_stop_select;
	assign o_debug_comm_allowed = !i_stop_mode || debug_enable;
	// active debug and full command set need enable
	assign o_active_debug_allowed = debug_enable;
	assign o_full_command_set = debug_enable && !i_secure;
	assign o_long_ack = i_ack_enabled && i_ack_issue && stop_seen;

	debug_bus_access #(
		.TIMEOUT(TIMEOUT)
	) u_access (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_req(i_access_req),
		.i_ack_enabled(i_ack_enabled),
		.i_steal(steal),
		.i_bus_free(i_bus_free),
		.o_grant(o_access_grant),
		.o_timeout(o_access_timeout)
	);
endmodule
`default_nettype wire

// ---- verification/debug_ctrl_status_upper_assertions.sv ----
// concurrent checks on the debug control/status upper byte ports
`timescale 1ns/1ps
`default_nettype none
module debug_ctrl_status_upper_checker #(
	parameter int TIMEOUT = debug_csr_pkg::FREE_WAIT_TIMEOUT
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_secure,
	input wire logic i_stop_mode,
	input wire logic i_reg_write_cmd,
	input wire logic i_reg_read_cmd,
	input wire logic i_debug_entry,
	input wire logic i_debug_exit,
	input wire logic i_fast_clock,
	input wire logic i_dedicated_debug_clock_input,
	input wire logic [7:0] o_read_data,
	input wire logic o_read_valid,
	input wire logic o_debug_enable,
	input wire logic o_active_debug_status,
	input wire logic o_continue_in_stop_select,
	input wire logic o_serial_clock_source_switch,
	input wire logic o_debug_serial_timing_clock,
	input wire logic o_all_clocks_run_in_stop,
	input wire logic o_active_debug_allowed,
	input wire logic o_access_grant,
	input wire logic o_access_timeout
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	read_answer_a: assert property (i_reg_read_cmd |=> o_read_valid)
		else $error("read answer missing");
	read_enable_a: assert property (o_read_valid |->
		o_read_data[7] == $past(o_debug_enable)) else $error("enable bit read");
	reserved_zero_a: assert property (o_read_valid |-> !o_read_data[4])
		else $error("reserved bit set");
	unsecure_indicator_read_a: assert property (o_read_valid |->
		o_read_data[1] == !$past(i_secure)) else $error("unsecure bit wrong");
	secure_write_a: assert property (i_reg_write_cmd && i_secure |=>
		$stable(o_debug_enable)) else $error("write accepted while secure");
	stop_hold_a: assert property (i_reg_write_cmd && i_stop_mode |=>
		$stable(o_continue_in_stop_select)) else $error("stop write taken");
	switch_sticky_a: assert property (o_serial_clock_source_switch |=>
		o_serial_clock_source_switch) else $error("clock switch cleared");
	clock_select_a: assert property (o_debug_serial_timing_clock ==
		(o_serial_clock_source_switch ? i_fast_clock :
		i_dedicated_debug_clock_input)) else $error("clock source wrong");
	stop_clocks_a: assert property (o_all_clocks_run_in_stop ==
		(o_debug_enable && o_continue_in_stop_select))
		else $error("stop clocks wrong");
	debug_allow_a: assert property (o_active_debug_allowed == o_debug_enable)
		else $error("debug allow wrong");
	entry_set_a: assert property (i_debug_entry && o_debug_enable |=>
		o_active_debug_status) else $error("active not set");
	exit_clear_a: assert property (i_debug_exit && !i_debug_entry |=>
		!o_active_debug_status) else $error("active not cleared");
	timeout_grant_a: assert property (o_access_timeout |-> o_access_grant)
		else $error("timeout without grant");
endmodule
bind debug_ctrl_status_upper debug_ctrl_status_upper_checker #(
	.TIMEOUT(TIMEOUT)) u_debug_ctrl_status_upper_checker (.*);
`default_nettype wire

// ---- verification/debug_host_model.sv ----
// debug host model issuing register read and write commands
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
	input wire logic i_ref_clk,
	input wire logic [7:0] i_read_data,
	input wire logic i_read_valid,
	output logic o_write_cmd,
	output logic [7:0] o_write_data,
	output logic o_read_cmd
);
	initial begin
		o_write_cmd = 1'h0;
		o_write_data = 8'h00;
		o_read_cmd = 1'h0;
	end
	task automatic wr(input logic [7:0] d);
		@(negedge i_ref_clk);
		o_write_cmd = 1'h1;
		o_write_data = d;
		@(negedge i_ref_clk);
		o_write_cmd = 1'h0;
		o_write_data = ~d;
		if (d[2])
			repeat (debug_csr_pkg::SERIAL_CLOCK_SOURCE_SWITCH_SETTLE_CYCLES) @(negedge i_ref_clk);
	endtask
	task automatic rd(output logic [7:0] q);
		@(negedge i_ref_clk);
		o_read_cmd = 1'h1;
		@(negedge i_ref_clk);
		o_read_cmd = 1'h0;
		q = i_read_valid ? i_read_data : 8'hXX;
	endtask
endmodule
`default_nettype wire

// ---- verification/debug_ctrl_status_upper_bench.sv ----
// self-checking bench for the debug control/status upper byte
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
`define PULSE(s) @(negedge i_ref_clk); s = 1'h1; @(negedge i_ref_clk); s = 1'h0;
module debug_ctrl_status_upper_bench;
	localparam int TMO = 4;
	logic i_ref_clk, i_reset, i_soft_reset;
	logic i_special_mode, i_secure, i_stop_mode;
	logic i_erase_cmd, i_erase_done, i_debug_entry;
	logic i_debug_exit, i_ack_enabled, i_ack_issue;
	logic i_access_req, i_bus_free, i_fast_clock;
	logic i_dedicated_debug_clock_input;
	wire i_reg_write_cmd, i_reg_read_cmd, o_read_valid, o_debug_enable;
	wire [7:0] i_write_data, o_read_data;
	wire o_active_debug_status, o_continue_in_stop_select, o_long_ack;
	wire o_serial_clock_source_switch, o_debug_serial_timing_clock;
	wire o_serial_clock_run_in_stop, o_all_clocks_run_in_stop;
	wire o_debug_comm_allowed, o_active_debug_allowed, o_full_command_set;
	wire o_access_grant, o_access_timeout;
	int fails = 0, checks = 0, cyc = 0;
	debug_ctrl_status_upper #(.TIMEOUT(TMO)) u_debug_ctrl_status_upper (.*);
	debug_host_model u_debug_host_model (.i_ref_clk(i_ref_clk),
		.i_read_data(o_read_data), .i_read_valid(o_read_valid),
		.o_write_cmd(i_reg_write_cmd), .o_write_data(i_write_data),
		.o_read_cmd(i_reg_read_cmd));
	initial begin
		i_ref_clk = 1'h0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	task automatic complete_run();
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			complete_run();
		end
	end
	task automatic rdchk(input logic [7:0] e);
		logic [7:0] q;
		u_debug_host_model.rd(q);
		`CHK("status byte", e, q)
	endtask
	task automatic acc(input int lo, input int hi, input logic et);
		int n;
		@(negedge i_ref_clk);
		i_access_req = 1'h1;
		@(negedge i_ref_clk);
		i_access_req = 1'h0;
		n = 1;
		while (o_access_grant !== 1'h1 && n < 20) begin
			@(negedge i_ref_clk);
			n++;
		end
		`CHK("grant window", 1'h1, n >= lo && n <= hi)
		`CHK("timeout", et, o_access_timeout)
	endtask
	task automatic do_reset();
		i_reset = 1'h1;
		repeat (3) @(negedge i_ref_clk);
		i_reset = 1'h0;
		@(negedge i_ref_clk);
	endtask
	initial begin
		i_reset = 1'h1;
		i_soft_reset = 1'h0;
		i_special_mode = 1'h1;
		i_secure = 1'h0;
		i_stop_mode = 1'h0;
		i_erase_cmd = 1'h0;
		i_erase_done = 1'h0;
		i_debug_entry = 1'h0;
		i_debug_exit = 1'h0;
		i_ack_enabled = 1'h0;
		i_ack_issue = 1'h0;
		i_access_req = 1'h0;
		i_bus_free = 1'h0;
		i_fast_clock = 1'h0;
		i_dedicated_debug_clock_input = 1'h1;
		do_reset();
		rdchk(8'hC2);
		`CHK("full commands", 1'h1, o_full_command_set)
		`CHK("serial in stop", 1'h1, o_serial_clock_run_in_stop)
		`CHK("timing clock", 1'h1, o_debug_serial_timing_clock)
		i_dedicated_debug_clock_input = 1'h0;
		#1 `CHK("timing clock", 1'h0, o_debug_serial_timing_clock)
		i_dedicated_debug_clock_input = 1'h1;
		acc(1, 1, 1'h0);
		u_debug_host_model.wr(8'hFF);
		rdchk(8'hEE);
		`CHK("timing clock", 1'h0, o_debug_serial_timing_clock)
		i_fast_clock = 1'h1;
		#1 `CHK("timing clock", 1'h1, o_debug_serial_timing_clock)
		i_fast_clock = 1'h0;
		i_ack_enabled = 1'h1;
		acc(1, 1, 1'h0);
		u_debug_host_model.wr(8'hA4);
		rdchk(8'hE6);
		i_bus_free = 1'h1;
		acc(2, 2, 1'h0);
		i_bus_free = 1'h0;
		acc(TMO, TMO + 2, 1'h1);
		i_stop_mode = 1'h1;
		@(negedge i_ref_clk);
		i_ack_issue = 1'h1;
		#1 `CHK("long ack", 1'h1, o_long_ack)
		@(negedge i_ref_clk);
		#1 `CHK("long ack", 1'h0, o_long_ack)
		i_ack_issue = 1'h0;
		i_stop_mode = 1'h0;
		@(negedge i_ref_clk);
		i_stop_mode = 1'h1;
		@(negedge i_ref_clk);
		i_ack_issue = 1'h1;
		#1 `CHK("long ack", 1'h1, o_long_ack)
		@(negedge i_ref_clk);
		i_ack_issue = 1'h0;
		`CHK("all clocks", 1'h1, o_all_clocks_run_in_stop)
		u_debug_host_model.wr(8'h84);
		rdchk(8'hE6);
		i_ack_enabled = 1'h0;
		u_debug_host_model.wr(8'h00);
		rdchk(8'h66);
		`CHK("comm in stop", 1'h0, o_debug_comm_allowed)
		i_stop_mode = 1'h0;
		u_debug_host_model.wr(8'h00);
		rdchk(8'h46);
		i_secure = 1'h1;
		u_debug_host_model.wr(8'h80);
		rdchk(8'h44);
		i_secure = 1'h0;
		`PULSE(i_erase_cmd)
		u_debug_host_model.wr(8'h00);
		rdchk(8'h47);
		`PULSE(i_erase_done)
		rdchk(8'h46);
		`PULSE(i_erase_cmd)
		`PULSE(i_soft_reset)
		rdchk(8'h46);
		`PULSE(i_debug_exit)
		`PULSE(i_debug_entry)
		rdchk(8'h06);
		u_debug_host_model.wr(8'h80);
		`PULSE(i_debug_entry)
		rdchk(8'hC6);
		`CHK("debug allowed", 1'h1, o_active_debug_allowed)
		i_special_mode = 1'h0;
		do_reset();
		rdchk(8'h02);
		`CHK("full commands", 1'h0, o_full_command_set)
		`CHK("serial in stop", 1'h0, o_serial_clock_run_in_stop)
		complete_run();
	end
endmodule
`default_nettype wire
